// [src/cdf_pkg.sv]
// Purpose: Shared constants for the channel diagnosis flag bank
// Assumes: Core clock of 50 MHz, eight channels, 4-bit registers
// Notes:   All offsets, field positions, reset values and timing counts live here
//
// Operation
// [RL1] Each channel latches its protection outcome in a protection fault flag.
// [RL2] Writing clear-protect-latch as 1 clears all protection fault flags.
// [RL3] Clear-protect-latch returns to 0 on the next valid frame.
// [RL4] Open-load result latched per channel; reading its register clears it.
// [RL5] No open-load diagnosis while a channel is on; flag stays untouched.
// [RL6] Off channel with open-load level sets its flag after 100 to 250 us.
// [RL7] Diagnosis current is enabled only while its enable bit is 1.
// [RL8] Over-temperature sets the protection flag and forces an active channel off.
// [RL9] Over-load switches the channel off within 60 us and sets its flag.
// [RL10] Diagnosis registers are read-only in bank 1; writes leave them alone.
// [RL11] Each diag register holds two channels: faults bits 2,0, open-load bits 3,1.
// [RL12] Protection flag reads 0 normally, 1 after over-load or over-temperature shutdown.
// [RL13] Open-load flag reads 0 normally, 1 after open load while off.
// [RL14] Command register at control address 110, clear-protect-latch at bit 0.
// [RL15] Command register holds soft-reset, standby and wake at bits 1, 2, 3.
// [RL16] A protected channel stays off until the clear-protect-latch command.
// [RL17] Over-temperature sets the protection flag in the off state too.
// [RL18] Diagnosis bank: four registers, 2-bit pointer, apart from eight control registers.
// [RL19] Open-load detection during the clearing read keeps the flag set.

package cdf_pkg;

	// Geometry
	localparam int NUM_CH       = 8;
	localparam int DATA_W       = 4;
	localparam int ADDR_W       = 3;
	localparam int DIAG_PTR_W   = 2;
	localparam int QUAL_CNT_W   = 13;

	// Bank selection
	localparam logic BANK_CONTROL = 1'b0;
	localparam logic BANK_DIAG    = 1'b1;

	// Diagnosis bank offsets
	localparam logic [DIAG_PTR_W-1:0] ADDR_DIAG_STATUS_CH0_1 = 2'h0;
	localparam logic [DIAG_PTR_W-1:0] ADDR_DIAG_STATUS_CH2_3 = 2'h1;
	localparam logic [DIAG_PTR_W-1:0] ADDR_DIAG_STATUS_CH4_5 = 2'h2;
	localparam logic [DIAG_PTR_W-1:0] ADDR_DIAG_STATUS_CH6_7 = 2'h3;

	// Control bank offsets
	localparam logic [ADDR_W-1:0] ADDR_DIAG_CURRENT_CONFIG0 = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_DIAG_CURRENT_CONFIG1 = 3'h5;
	localparam logic [ADDR_W-1:0] ADDR_COMMAND_REG          = 3'h6;

	// Diagnosis register fields
	localparam int DIAG_PF_LO_BIT = 0;
	localparam int DIAG_OL_LO_BIT = 1;
	localparam int DIAG_PF_HI_BIT = 2;
	localparam int DIAG_OL_HI_BIT = 3;

	// Command register fields
	localparam int CMD_CLEAR_PROTECT_BIT = 0;
	localparam int CMD_SOFT_RESET_BIT    = 1;
	localparam int CMD_STANDBY_BIT       = 2;
	localparam int CMD_WAKE_BIT          = 3;

	// Reset values
	localparam logic [DATA_W-1:0] CMD_RESET    = 4'h0;
	localparam logic [NUM_CH-1:0] DCC_RESET    = 8'h00;
	localparam logic [NUM_CH-1:0] FLAGS_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_RESET  = 4'h0;

	// Timing
	localparam int CLK_MHZ                = 50;
	localparam int OPEN_LOAD_QUAL_MIN_US  = 100;
	localparam int OPEN_LOAD_QUAL_MAX_US  = 250;
	localparam int OPEN_LOAD_QUAL_CYCLES  = OPEN_LOAD_QUAL_MIN_US * CLK_MHZ;
	localparam int OVERLOAD_SHUTOFF_MAX_US = 60;
	localparam int OVERLOAD_SHUTOFF_CYCLES = OVERLOAD_SHUTOFF_MAX_US * CLK_MHZ;

endpackage

// [src/cdf_qual_if.sv]
// Purpose: Carries off-state and open-load signals between controller and qualifier
// Assumes: One bit per channel
// Notes:   Both modules run on the same core clock

interface cdf_qual_if;

	logic [7:0] off_state;
	logic [7:0] open_load_level;
	logic [7:0] ol_detect;

	modport ctrl (
		output off_state,
		output open_load_level,
		input  ol_detect
	);

	modport qual (
		input  off_state,
		input  open_load_level,
		output ol_detect
	);

endinterface

// [src/cdf_ol_qual.sv]
// Purpose: Per-channel open-load qualification timer
// Assumes: Level inputs synchronous to the core clock
// Notes:   Detection stays high while the qualified condition persists

module cdf_ol_qual #(
	parameter int QUAL_CYCLES = cdf_pkg::OPEN_LOAD_QUAL_CYCLES
) (
	// Clock and reset
	input  wire logic  core_clk_in,
	input  wire logic  reset_in,
	// Channel signals
	cdf_qual_if.qual   qual_if
);

	typedef struct packed {
		logic [cdf_pkg::NUM_CH-1:0][cdf_pkg::QUAL_CNT_W-1:0] cnt;
		logic [cdf_pkg::NUM_CH-1:0]                          detect;
	} cdf_qual_state_t;

	localparam logic [cdf_pkg::QUAL_CNT_W-1:0] LAST_CNT =
		cdf_pkg::QUAL_CNT_W'(QUAL_CYCLES - 1);

	cdf_qual_state_t st_q;
	cdf_qual_state_t st_d;

	always_comb begin
		st_d = st_q;
		for (int ch = 0; ch < cdf_pkg::NUM_CH; ch++) begin
			st_d.detect[ch] = 1'b0;
			// Count only while off and the output shows open load
			if (qual_if.off_state[ch] && qual_if.open_load_level[ch]) begin // RL5
				if (st_q.cnt[ch] == LAST_CNT) begin
					st_d.detect[ch] = 1'b1; // RL6
				end else begin
					st_d.cnt[ch] = st_q.cnt[ch] + 1'b1;
				end
			end else begin
				st_d.cnt[ch] = '0;
			end
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign qual_if.ol_detect = st_q.detect;

endmodule

// [src/cdf_diag_flags.sv]
// Purpose: Protection and open-load flag bank with command and diag-current registers
// Assumes: Frame engine delivers one decoded access per valid frame, synchronous to clock
// Notes:   Read data is captured at the access and held until the next read

module cdf_diag_flags #(
	parameter int OL_QUAL_CYCLES = cdf_pkg::OPEN_LOAD_QUAL_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,

	// Decoded register access from frame engine
	input  wire logic        frame_valid_in,
	input  wire logic        reg_write_in,
	input  wire logic        bank_select_in,
	input  wire logic [2:0]  reg_addr_in,
	input  wire logic [3:0]  reg_wdata_in,
	output logic      [3:0]  reg_rdata_out,

	// Channel requests and analog indications
	input  wire logic [7:0]  ch_request_in,
	input  wire logic [7:0]  overload_in,
	input  wire logic [7:0]  overtemp_in,
	input  wire logic [7:0]  open_load_level_in,

	// Channel controls
	output logic      [7:0]  ch_enable_out,
	output logic      [7:0]  diag_current_enable_out,

	// Flag view
	output logic      [7:0]  prot_fault_flag_out,
	output logic      [7:0]  open_load_flag_out,
	output logic      [3:0]  std_diag_out,

	// Command bits; soft-reset, standby and wake handled elsewhere
	output logic             clear_protect_latch_out,
	output logic             soft_reset_out,
	output logic             standby_bit_out,
	output logic             wake_out
);

	typedef struct packed {
		logic [7:0] prot_fault_flag;
		logic [7:0] open_load_flag;
		logic [7:0] ch_enable;
		logic [7:0] diag_current_config;
		logic [3:0] command_reg;
		logic [3:0] rdata;
		logic [3:0] std_diag;
	} cdf_state_t;

	cdf_state_t st_q;
	cdf_state_t st_d;

	cdf_qual_if qual_if ();

	// Pack one diagnosis register from a channel pair
	function automatic logic [3:0] diag_word(
		input logic [7:0] pf,
		input logic [7:0] ol,
		input logic [1:0] ptr
	);
		logic [3:0] w;
		w = '0;
		w[cdf_pkg::DIAG_PF_LO_BIT] = pf[{ptr, 1'b0}]; // RL11
		w[cdf_pkg::DIAG_OL_LO_BIT] = ol[{ptr, 1'b0}]; // RL11
		w[cdf_pkg::DIAG_PF_HI_BIT] = pf[{ptr, 1'b1}]; // RL11
		w[cdf_pkg::DIAG_OL_HI_BIT] = ol[{ptr, 1'b1}]; // RL11
		return w;
	endfunction

	// Mask of the two channels that a diagnosis pointer selects
	function automatic logic [7:0] pair_mask(input logic [1:0] ptr);
		logic [7:0] m;
		m = '0;
		m[{ptr, 1'b0}] = 1'b1;
		m[{ptr, 1'b1}] = 1'b1;
		return m;
	endfunction

	// Open-load qualification timers
	cdf_ol_qual #(
		.QUAL_CYCLES (OL_QUAL_CYCLES)
	) u_ol_qual (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.qual_if     (qual_if.qual)
	);

	assign qual_if.off_state       = ~st_q.ch_enable; // RL5
	assign qual_if.open_load_level = open_load_level_in;

	always_comb begin
		logic       wr_ctrl;
		logic       rd_ctrl;
		logic       rd_diag;
		logic       cpl_write;
		logic [1:0] ptr;
		logic [7:0] pf_set;
		logic [7:0] pf_clr;
		logic [7:0] ol_clr;

		st_d      = st_q;
		pf_set    = 8'h00;
		pf_clr    = 8'h00;
		ol_clr    = 8'h00;
		ptr       = reg_addr_in[cdf_pkg::DIAG_PTR_W-1:0];
		wr_ctrl   = frame_valid_in && reg_write_in && (bank_select_in == cdf_pkg::BANK_CONTROL);
		rd_ctrl   = frame_valid_in && !reg_write_in && (bank_select_in == cdf_pkg::BANK_CONTROL);
		// Diagnosis bank answers reads only; writes to it fall through
		rd_diag   = frame_valid_in && !reg_write_in
			&& (bank_select_in == cdf_pkg::BANK_DIAG); // RL10
		cpl_write = wr_ctrl && (reg_addr_in == cdf_pkg::ADDR_COMMAND_REG)
			&& reg_wdata_in[cdf_pkg::CMD_CLEAR_PROTECT_BIT];

		// Protection events: over-temperature in any state, over-load while on
		pf_set = overtemp_in | (overload_in & st_q.ch_enable); // RL8 RL9 RL17
		pf_clr = cpl_write ? 8'hff : 8'h00; // RL2
		st_d.prot_fault_flag = (st_q.prot_fault_flag & ~pf_clr) | pf_set; // RL1 RL12

		// Open-load flags: read clears the pair, a new detection wins
		ol_clr = (rd_diag && (reg_addr_in[2] == 1'b0)) ? pair_mask(ptr) : 8'h00; // RL4 RL18
		// A detection left over from the cycle a channel turns on is dropped
		st_d.open_load_flag = (st_q.open_load_flag & ~ol_clr)
			| (qual_if.ol_detect & ~st_q.ch_enable); // RL4 RL5 RL13 RL19

		// Channel drive: a latched fault keeps the channel off
		st_d.ch_enable = ch_request_in & ~st_d.prot_fault_flag; // RL8 RL9 RL16

		// Control bank writes
		if (wr_ctrl) begin
			case (reg_addr_in)
				cdf_pkg::ADDR_DIAG_CURRENT_CONFIG0: begin
					st_d.diag_current_config[3:0] = reg_wdata_in; // RL7
				end
				cdf_pkg::ADDR_DIAG_CURRENT_CONFIG1: begin
					st_d.diag_current_config[7:4] = reg_wdata_in; // RL7
				end
				cdf_pkg::ADDR_COMMAND_REG: begin
					st_d.command_reg = reg_wdata_in; // RL14 RL15
				end
				default: begin
					st_d.command_reg = st_q.command_reg;
				end
			endcase
		end

		// Clear-protect-latch drops on the next valid frame
		if (frame_valid_in && !cpl_write) begin
			st_d.command_reg[cdf_pkg::CMD_CLEAR_PROTECT_BIT] = 1'b0; // RL3
		end

		// Read data capture
		if (rd_diag) begin
			if (reg_addr_in[2] == 1'b0) begin
				st_d.rdata = diag_word(st_q.prot_fault_flag, st_q.open_load_flag, ptr); // RL11
			end else begin
				st_d.rdata = '0; // RL18
			end
		end else if (rd_ctrl) begin
			case (reg_addr_in)
				cdf_pkg::ADDR_DIAG_CURRENT_CONFIG0: begin
					st_d.rdata = st_q.diag_current_config[3:0];
				end
				cdf_pkg::ADDR_DIAG_CURRENT_CONFIG1: begin
					st_d.rdata = st_q.diag_current_config[7:4];
				end
				cdf_pkg::ADDR_COMMAND_REG: begin
					st_d.rdata = st_q.command_reg; // RL14
				end
				default: begin
					st_d.rdata = '0;
				end
			endcase
		end

		// Standard diagnosis summary, one bit per channel pair
		for (int p = 0; p < 4; p++) begin
			st_d.std_diag[p] = st_q.prot_fault_flag[2*p] | st_q.prot_fault_flag[2*p+1];
		end
	end

	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st_q.prot_fault_flag     <= cdf_pkg::FLAGS_RESET;
			st_q.open_load_flag      <= cdf_pkg::FLAGS_RESET;
			st_q.ch_enable           <= cdf_pkg::FLAGS_RESET;
			st_q.diag_current_config <= cdf_pkg::DCC_RESET;
			st_q.command_reg         <= cdf_pkg::CMD_RESET;
			st_q.rdata               <= cdf_pkg::RDATA_RESET;
			st_q.std_diag            <= cdf_pkg::RDATA_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata_out           = st_q.rdata;
	assign ch_enable_out           = st_q.ch_enable;
	assign diag_current_enable_out = st_q.diag_current_config; // RL7
	assign prot_fault_flag_out     = st_q.prot_fault_flag;
	assign open_load_flag_out      = st_q.open_load_flag;
	assign std_diag_out            = st_q.std_diag;
	assign clear_protect_latch_out = st_q.command_reg[cdf_pkg::CMD_CLEAR_PROTECT_BIT];
	assign soft_reset_out          = st_q.command_reg[cdf_pkg::CMD_SOFT_RESET_BIT]; // RL15
	assign standby_bit_out         = st_q.command_reg[cdf_pkg::CMD_STANDBY_BIT]; // RL15
	assign wake_out                = st_q.command_reg[cdf_pkg::CMD_WAKE_BIT]; // RL15

endmodule

// [dv/cdf_host_model.sv]
// Purpose: Bus master model issuing decoded register accesses
// Assumes: One access per frame, driven 1 ns after the rising edge
// Notes:   Request held for exactly one sampling edge
module cdf_host_model (
	// Clock
	input  wire logic       clk_in,
	// Access
	output logic            fv_out,
	output logic            wr_out,
	output logic            bs_out,
	output logic      [2:0] ad_out,
	output logic      [3:0] wd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{fv_out, wr_out, bs_out, ad_out, wd_out} = '0;
	end
	task automatic access(input logic w, input logic b, input logic [2:0] a,
		input logic [3:0] d);
		@(posedge clk_in);
		#1;
		{fv_out, wr_out, bs_out, ad_out, wd_out} = {1'b1, w, b, a, d};
		@(posedge clk_in);
		#1;
		fv_out = 1'b0;
	endtask
endmodule

// [dv/cdf_diag_flags_asserts.sv]
// Purpose: Port-level checks of the flag bank
// Assumes: One clock domain, async active-high reset
// Notes:   Bound into the flag bank module cdf_diag_flags
module cdf_diag_flags_asserts (
	// Clock and reset
	input wire logic       core_clk_in,
	input wire logic       reset_in,
	// Access
	input wire logic       frame_valid_in,
	input wire logic       reg_write_in,
	input wire logic       bank_select_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [3:0] reg_wdata_in,
	input wire logic [3:0] reg_rdata_out,
	// Channels
	input wire logic [7:0] overload_in,
	input wire logic [7:0] overtemp_in,
	input wire logic [7:0] ch_enable_out,
	input wire logic [7:0] diag_current_enable_out,
	input wire logic [7:0] prot_fault_flag_out,
	input wire logic [7:0] open_load_flag_out,
	input wire logic       clear_protect_latch_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	wire cw = frame_valid_in && reg_write_in && !bank_select_in;
	AST_OT: assert property (1 |=> (prot_fault_flag_out & $past(overtemp_in)) == $past(overtemp_in)
		&& (ch_enable_out & $past(overtemp_in)) == 8'h00) else $error("overtemp missed");
	AST_OVL: assert property (1 |=> ((prot_fault_flag_out & ~ch_enable_out) &
		$past(overload_in & ch_enable_out)) == $past(overload_in & ch_enable_out))
		else $error("overload missed");
	AST_HOLD: assert property ((ch_enable_out & prot_fault_flag_out) == 8'h00)
		else $error("faulted channel on");
	AST_CLR: assert property (cw && reg_addr_in == 3'h6 && reg_wdata_in[0] && overtemp_in == 8'h00
		&& (overload_in & ch_enable_out) == 8'h00 |=> prot_fault_flag_out == 8'h00
		&& clear_protect_latch_out) else $error("clear failed");
	AST_CPL: assert property (clear_protect_latch_out && frame_valid_in &&
		!(cw && reg_addr_in == 3'h6 && reg_wdata_in[0]) |=> !clear_protect_latch_out)
		else $error("clear bit stuck");
	AST_OLON: assert property (1 |=> (open_load_flag_out & ~$past(open_load_flag_out)
		& $past(ch_enable_out)) == 8'h00) else $error("open load while on");
	AST_RO: assert property (frame_valid_in && reg_write_in |=> $stable(reg_rdata_out))
		else $error("write changed read data");
	AST_DCC: assert property (cw && reg_addr_in == 3'h4 |=>
		diag_current_enable_out[3:0] == $past(reg_wdata_in)) else $error("diag current");
	AST_MAP: assert property (frame_valid_in && !reg_write_in && bank_select_in &&
		reg_addr_in == 3'h0 |=> reg_rdata_out == {$past(open_load_flag_out[1]),
		$past(prot_fault_flag_out[1]), $past(open_load_flag_out[0]),
		$past(prot_fault_flag_out[0])}) else $error("diag map");
endmodule
bind cdf_diag_flags cdf_diag_flags_asserts u_asserts (.*);

// [dv/cdf_diag_flags_bench.sv]
// Purpose: Self-checking bench of the flag bank against a bench model
// Assumes: Qualification shortened to 8 cycles
// Notes:   Host model issues all register accesses
module cdf_diag_flags_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0, reset_in = 1'b1;
	logic [7:0] req, ovl, ot, oll, en, dce, pf, ol, epf, eol, edce;
	logic       fv, wr, bs;
	logic [2:0] ad;
	logic [3:0] wd, rd, d, sd;
	logic       clear_protect_latch, srst, stby, wk;
	logic [31:0] rs = 32'hf64d;
	int         error_cnt = 0, n_checks = 0, c;
	initial forever #10 clk = ~clk;
	cdf_host_model host (.clk_in(clk), .fv_out(fv), .wr_out(wr), .bs_out(bs), .ad_out(ad),
		.wd_out(wd));
	cdf_diag_flags #(.OL_QUAL_CYCLES(8)) dut (.core_clk_in(clk), .reset_in(reset_in),
		.frame_valid_in(fv), .reg_write_in(wr), .bank_select_in(bs), .reg_addr_in(ad),
		.reg_wdata_in(wd), .reg_rdata_out(rd), .ch_request_in(req), .overload_in(ovl),
		.overtemp_in(ot), .open_load_level_in(oll), .ch_enable_out(en),
		.diag_current_enable_out(dce), .prot_fault_flag_out(pf), .open_load_flag_out(ol),
		.std_diag_out(sd), .clear_protect_latch_out(clear_protect_latch), .soft_reset_out(srst),
		.standby_bit_out(stby), .wake_out(wk));
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [3:0] dw(int p);
		return {eol[2*p+1], epf[2*p+1], eol[2*p], epf[2*p]};
	endfunction
	function automatic logic [3:0] sdx();
		logic [3:0] r;
		r = 4'h0;
		for (int p = 0; p < 4; p++) r[p] = epf[2*p] | epf[2*p+1];
		return r;
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rdreg(logic b, logic [2:0] a, logic [3:0] e);
		host.access(1'b0, b, a, 4'h0);
		chk("rdata", {4'h0, e}, {4'h0, rd});
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		{req, ovl, ot, oll, epf, eol, edce} = '0;
		cyc(3);
		reset_in = 1'b0;
		for (int p = 0; p < 4; p++) rdreg(1'b1, p[2:0], 4'h0);
		rdreg(1'b0, 3'h6, 4'h0);
		req = 8'h7f;
		cyc(2);
		for (int k = 0; k < 8; k++) begin
			ot = 8'h01 << k;
			cyc(1);
			ot = 8'h00;
			epf[k] = 1'b1;
			cyc(1);
			chk("enable", req & ~epf, en);
			chk("std", {4'h0, sdx()}, {4'h0, sd});
			rdreg(1'b1, k / 2, dw(k / 2));
		end
		host.access(1'b1, 1'b0, 3'h6, 4'h1);
		epf = 8'h00;
		chk("pf", epf, pf);
		chk("cmd", 8'h01, {4'h0, wk, stby, srst, clear_protect_latch});
		rdreg(1'b0, 3'h6, 4'h1);
		chk("cmd", 8'h00, {4'h0, wk, stby, srst, clear_protect_latch});
		rdreg(1'b0, 3'h6, 4'h0);
		req = 8'hff;
		cyc(2);
		c = xs() % 8;
		ovl = 8'h01 << c;
		cyc(1);
		ovl = 8'h00;
		epf[c] = 1'b1;
		cyc(1);
		chk("enable", req & ~epf, en);
		chk("std", {4'h0, sdx()}, {4'h0, sd});
		host.access(1'b1, 1'b1, c / 2, 4'hf);
		rdreg(1'b1, c / 2, dw(c / 2));
		host.access(1'b1, 1'b0, 3'h6, 4'h1);
		epf = 8'h00;
		req = 8'h0f;
		oll = 8'hff;
		cyc(9);
		chk("ol", 8'h00, ol);
		for (int i = 0; i < 2 && ol !== 8'hf0; i++) cyc(1);
		eol = 8'hf0;
		chk("ol", eol, ol);
		rdreg(1'b1, 3'h3, dw(3));
		chk("ol", eol, ol);
		oll = 8'h00;
		cyc(2);
		rdreg(1'b1, 3'h2, dw(2));
		eol[5:4] = 2'h0;
		chk("ol", eol, ol);
		for (int a = 4; a < 6; a++) begin
			d = xs();
			host.access(1'b1, 1'b0, a, d);
			edce[(a-4)*4 +: 4] = d;
			rdreg(1'b0, a, d);
			chk("dce", edce, dce);
		end
		rdreg(1'b0, 3'h7, 4'h0);
		host.access(1'b1, 1'b0, 3'h6, 4'he);
		rdreg(1'b0, 3'h6, 4'he);
		chk("cmd", 8'h0e, {4'h0, wk, stby, srst, clear_protect_latch});
		report_and_stop();
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule
